// ---- inc/pdm_cfg.svh ----
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH

// register index, taken from bus address bits [7:2]
`define PDM_REG_DATA_IN   6'h00
`define PDM_REG_DATA_OUT  6'h01
`define PDM_REG_DIR       6'h02
`define PDM_REG_OCELL     6'h03
`define PDM_REG_MASK      6'h04
`define PDM_REG_ICELL     6'h05
`define PDM_REG_EN_STAT   6'h06

// field positions inside the bus address
`define PDM_ADDR_REG_MSB  7
`define PDM_ADDR_REG_LSB  2
`define PDM_ADDR_PORT_MSB 1
`define PDM_ADDR_PORT_LSB 0

// chip select and logic clock sit on fixed port D pins
`define PDM_PIN_D_CLOCK   1
`define PDM_PIN_D_CSI     2

// reset values and read of anything unmapped
`define PDM_RST_BYTE      8'h00
`define PDM_RST_BIT       1'h0
`define PDM_UNMAPPED      8'h00
`define PDM_D_PIN_MASK    8'h07

`endif

// ---- inc/pdm_pkg.sv ----
package pdm_pkg;

  // port selected by address bits [1:0]
  typedef enum logic [1:0] {
    PDM_PORT_A,
    PDM_PORT_B,
    PDM_PORT_C,
    PDM_PORT_D
  } pdm_port_t;

  // one processor bus cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdm_bus_req_t;

  // static configuration set when the logic is programmed
  typedef struct packed {
    logic route_first_to_b;
    logic route_second_to_b;
    logic logic_clock_sel;
    logic csi_sel;
  } pdm_cfg_t;

  // internal memory and register block enables
  typedef struct packed {
    logic flash_en;
    logic sram_en;
    logic io_block_en;
  } pdm_mem_en_t;

endpackage : pdm_pkg

// ---- logic/pdm_pin_drv.sv ----
`timescale 1ns/1ns
module pdm_pin_drv #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_in,     // system clock
  input  wire logic             reset_in,       // sync reset, high
  input  wire logic [WIDTH-1:0] pin_in,         // raw pin levels
  input  wire logic [WIDTH-1:0] data_in,        // value to drive
  input  wire logic [WIDTH-1:0] dir_in,         // direction bits
  input  wire logic [WIDTH-1:0] oe_term_in,     // output-enable terms
  output logic      [WIDTH-1:0] pin_out,        // driven level
  output logic      [WIDTH-1:0] pin_oe_out,     // driver on, high
  output logic      [WIDTH-1:0] pin_sync_out    // pins after two flops
);

  logic [WIDTH-1:0] meta_reg;

  // pins are asynchronous: two flops before anyone looks
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      meta_reg     <= '0;
      pin_sync_out <= '0;
    end
    else
    begin
      meta_reg     <= pin_in;
      pin_sync_out <= meta_reg;
    end
  end

  // driver on when direction or product term is 1
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pin_out    <= '0;
      pin_oe_out <= '0;
    end
    else
    begin
      pin_out    <= data_in;
      pin_oe_out <= dir_in | oe_term_in;
    end
  end

endmodule : pdm_pin_drv

// ---- logic/pdm_port_regs.sv ----
// What this block does
// - pin drives data-out bit, or cell output / external select where chosen, when direction bit or output-enable term is 1
// - data-out read returns last written value, not pin levels
// - output cell location read returns current cell flip-flop outputs
// - output cell write loads flip-flops whose mask bit is clear
// - one mask bit per cell flip-flop; set bit blocks processor loads
// - mask bits reset to 0, all cells loadable after reset
// - input cells feed logic input bus and are readable by processor
// - enable status bit is 1 when driving, 0 when tri-stated
// - enable status is read-only, shows effective driver enable
// - mask register read/write for ports A, B, C only; none on D
// - first cell group to port A or B; second to B or C
// - port C has no address-out mode and no mode register
// - port D has three pins, no address-out, no input cells
// - chip-select input high disables flash, SRAM and register block select
// - chip-select input never blocks logic signals or the logic array
// - each external select is one product term with selectable polarity
// - external select driver enabled by output-enable term or direction bit
// - port D logic clock pin clocks cell flip-flops
// - direction 1 is output, 0 input; all reset to input
// - data-in read returns pin levels after the two-flop synchroniser
`timescale 1ns/1ns
`include "pdm_cfg.svh"
module pdm_port_regs (
  input  wire logic                       clk_sys_in,          // system clock
  input  wire logic                       reset_in,            // sync reset, high
  input  wire pdm_pkg::pdm_bus_req_t      bus_req_in,          // processor cycle
  input  wire logic                       io_reg_sel_in,       // register block decode
  output logic                      [7:0] bus_rdata_out,       // read data, registered
  input  wire pdm_pkg::pdm_cfg_t          cfg_in,              // programmed options
  input  wire logic                 [2:0][7:0] pin_abc_in,     // pins of ports A..C
  output logic                      [2:0][7:0] pin_abc_out,    // driven levels A..C
  output logic                      [2:0][7:0] pin_abc_oe_out, // driver enables A..C
  input  wire logic                 [2:0][7:0] oe_term_abc_in, // enable terms A..C
  input  wire logic                 [2:0][7:0] cell_sel_abc_in,// pin shows cell output
  input  wire logic                 [2:0] pin_d_in,            // port D pins
  output logic                      [2:0] pin_d_out,           // port D driven levels
  output logic                      [2:0] pin_d_oe_out,        // port D driver enables
  input  wire logic                 [2:0] oe_term_d_in,        // port D enable terms
  input  wire logic                 [2:0] ecs_term_in,         // select product terms
  input  wire logic                 [2:0] ecs_active_low_in,   // select polarity
  input  wire logic                 [2:0] ecs_sel_in,          // pin carries select
  input  wire logic                 [7:0] cell_first_d_in,     // array next, group 1
  input  wire logic                 [7:0] cell_second_d_in,    // array next, group 2
  output logic                      [7:0] cell_first_out,      // group 1 flip-flops
  output logic                      [7:0] cell_second_out,     // group 2 flip-flops
  output logic                      [2:0][7:0] logic_input_bus_out, // input cells
  output logic                      [2:0] port_d_logic_out,    // port D direct inputs
  output pdm_pkg::pdm_mem_en_t            mem_en_out           // memory enables
);

  localparam int PA = 0;
  localparam int PB = 1;
  localparam int PC = 2;
  localparam int PD = 3;

  logic [3:0][7:0] data_out_reg;
  logic [3:0][7:0] dir_reg;
  logic [2:0][7:0] mask_reg;
  logic [2:0][7:0] icell_reg;
  logic [7:0]      cell_first_reg;
  logic [7:0]      cell_second_reg;
  logic [7:0]      rdata_reg;
  logic            clk_pin_prev_reg;
  pdm_pkg::pdm_mem_en_t mem_en_reg;

  logic [3:0][7:0] pin_raw;
  logic [3:0][7:0] pin_drive;
  logic [3:0][7:0] oe_term;
  logic [3:0][7:0] pin_lvl;
  logic [3:0][7:0] pin_oe;
  logic [3:0][7:0] pin_sync;
  logic [2:0][7:0] ocell_view;
  logic [7:0]      mask_first;
  logic [7:0]      mask_second;
  logic [7:0]      cell_first_next;
  logic [7:0]      cell_second_next;
  logic [7:0]      rdata_next;
  logic [2:0]      ecs_level;
  logic [5:0]      reg_idx;
  pdm_pkg::pdm_port_t port_idx;
  logic            csi_active;
  logic            access_ok;
  logic            wr_ok;
  logic            rd_ok;
  logic            cell_tick;
  logic            wr_first;
  logic            wr_second;

  // address split and access qualification
  assign reg_idx    = bus_req_in.addr[`PDM_ADDR_REG_MSB:`PDM_ADDR_REG_LSB];
  assign port_idx   = pdm_pkg::pdm_port_t'(bus_req_in.addr[`PDM_ADDR_PORT_MSB:`PDM_ADDR_PORT_LSB]);
  assign csi_active = cfg_in.csi_sel & pin_sync[PD][`PDM_PIN_D_CSI];
  assign access_ok  = io_reg_sel_in & ~csi_active;
  assign wr_ok      = bus_req_in.wr & access_ok;
  assign rd_ok      = bus_req_in.rd & access_ok;

  // logic clock pin edge; without it the cells step every system clock
  assign cell_tick = cfg_in.logic_clock_sel
                   ? (pin_sync[PD][`PDM_PIN_D_CLOCK] & ~clk_pin_prev_reg)
                   : 1'h1;

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      clk_pin_prev_reg <= `PDM_RST_BIT;
    else
      clk_pin_prev_reg <= pin_sync[PD][`PDM_PIN_D_CLOCK];
  end

  // group routing: which cells a port location and its pins see
  always_comb
  begin
    ocell_view[PA] = cell_first_reg;
    ocell_view[PB] = cfg_in.route_first_to_b ? cell_first_reg : cell_second_reg;
    ocell_view[PC] = cell_second_reg;
    mask_first     = cfg_in.route_first_to_b ? mask_reg[PB] : mask_reg[PA];
    mask_second    = cfg_in.route_second_to_b ? mask_reg[PB] : mask_reg[PC];
  end

  // a port B write loads only groups actually routed there
  always_comb
  begin
    wr_first  = 1'h0;
    wr_second = 1'h0;
    if (wr_ok && reg_idx == `PDM_REG_OCELL)
    begin
      case (port_idx)
        pdm_pkg::PDM_PORT_A: wr_first  = 1'h1;
        pdm_pkg::PDM_PORT_B:
        begin
          wr_first  = cfg_in.route_first_to_b;
          wr_second = cfg_in.route_second_to_b;
        end
        pdm_pkg::PDM_PORT_C: wr_second = 1'h1;
        default:             wr_first  = 1'h0; // port D has no cells
      endcase
    end
  end

  // cell next value: array load on tick, masked processor write on top
  always_comb
  begin
    cell_first_next  = cell_tick ? cell_first_d_in : cell_first_reg;
    cell_second_next = cell_tick ? cell_second_d_in : cell_second_reg;
    if (wr_first)
      cell_first_next = (bus_req_in.wdata & ~mask_first)
                      | (cell_first_next & mask_first);
    if (wr_second)
      cell_second_next = (bus_req_in.wdata & ~mask_second)
                       | (cell_second_next & mask_second);
  end

  // output cell flip-flops keep running whatever the chip select does
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      cell_first_reg  <= `PDM_RST_BYTE;
      cell_second_reg <= `PDM_RST_BYTE;
    end
    else
    begin
      cell_first_reg  <= cell_first_next;
      cell_second_reg <= cell_second_next;
    end
  end

  // input cells latch synchronised pins of A..C on each tick
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      icell_reg <= '0;
    else if (cell_tick)
      icell_reg <= pin_sync[2:0];
  end

  // data-out latches; port D keeps only its three pins
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      data_out_reg <= '0;
    else if (wr_ok && reg_idx == `PDM_REG_DATA_OUT)
    begin
      if (port_idx == pdm_pkg::PDM_PORT_D)
        data_out_reg[PD] <= bus_req_in.wdata & `PDM_D_PIN_MASK;
      else
        data_out_reg[port_idx] <= bus_req_in.wdata;
    end
  end

  // direction bits, all inputs after reset
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      dir_reg <= '0;
    else if (wr_ok && reg_idx == `PDM_REG_DIR)
    begin
      if (port_idx == pdm_pkg::PDM_PORT_D)
        dir_reg[PD] <= bus_req_in.wdata & `PDM_D_PIN_MASK;
      else
        dir_reg[port_idx] <= bus_req_in.wdata;
    end
  end

  // mask registers exist for A..C; a port D write is dropped
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      mask_reg <= '0;
    else if (wr_ok && reg_idx == `PDM_REG_MASK && port_idx != pdm_pkg::PDM_PORT_D)
      mask_reg[port_idx] <= bus_req_in.wdata;
  end

  // read mux; read-only locations have no write path at all
  always_comb
  begin
    rdata_next = `PDM_UNMAPPED;
    case (reg_idx)
      `PDM_REG_DATA_IN:  rdata_next = pin_sync[port_idx];
      `PDM_REG_DATA_OUT: rdata_next = data_out_reg[port_idx];
      `PDM_REG_DIR:      rdata_next = dir_reg[port_idx];
      `PDM_REG_OCELL:
        if (port_idx != pdm_pkg::PDM_PORT_D)
          rdata_next = ocell_view[port_idx];
      `PDM_REG_MASK:
        if (port_idx != pdm_pkg::PDM_PORT_D)
          rdata_next = mask_reg[port_idx];
      `PDM_REG_ICELL:
        if (port_idx != pdm_pkg::PDM_PORT_D)
          rdata_next = icell_reg[port_idx];
      `PDM_REG_EN_STAT:
        if (port_idx != pdm_pkg::PDM_PORT_D)
          rdata_next = pin_oe[port_idx];
      default:           rdata_next = `PDM_UNMAPPED;
    endcase
  end

  // read data held until the next accepted read
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      rdata_reg <= `PDM_RST_BYTE;
    else if (rd_ok)
      rdata_reg <= rdata_next;
  end

  // flash and SRAM enables follow the chip-select input only; register block also needs io_reg_sel_in
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      mem_en_reg <= '0;
    else
    begin
      mem_en_reg.flash_en    <= ~csi_active;
      mem_en_reg.sram_en     <= ~csi_active;
      mem_en_reg.io_block_en <= access_ok;
    end
  end

  // external selects: one term each, polarity by xor
  assign ecs_level = ecs_term_in ^ ecs_active_low_in;

  // pin data: cell output (A..C) or select level (D) where selected, else the data-out latch
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      pin_drive[p] = (cell_sel_abc_in[p] & ocell_view[p])
                   | (~cell_sel_abc_in[p] & data_out_reg[p]);
      oe_term[p]   = oe_term_abc_in[p];
      pin_raw[p]   = pin_abc_in[p];
    end
    pin_drive[PD] = {5'h00, (ecs_sel_in & ecs_level)
                          | (~ecs_sel_in & data_out_reg[PD][2:0])};
    oe_term[PD]   = {5'h00, oe_term_d_in};
    pin_raw[PD]   = {5'h00, pin_d_in};
  end

  // one driver and synchroniser per port; no address-out path exists
  for (genvar g = 0; g < 4; g++)
  begin : g_port
    pdm_pin_drv #(
      .WIDTH        (8)
    ) u_drv (
      .clk_sys_in   (clk_sys_in),
      .reset_in     (reset_in),
      .pin_in       (pin_raw[g]),
      .data_in      (pin_drive[g]),
      .dir_in       (dir_reg[g]),
      .oe_term_in   (oe_term[g]),
      .pin_out      (pin_lvl[g]),
      .pin_oe_out   (pin_oe[g]),
      .pin_sync_out (pin_sync[g])
    );
  end

  // outputs
  assign bus_rdata_out       = rdata_reg;
  assign pin_abc_out         = pin_lvl[2:0];
  assign pin_abc_oe_out      = pin_oe[2:0];
  assign pin_d_out           = pin_lvl[PD][2:0];
  assign pin_d_oe_out        = pin_oe[PD][2:0];
  assign cell_first_out      = cell_first_reg;
  assign cell_second_out     = cell_second_reg;
  assign logic_input_bus_out = icell_reg;
  assign port_d_logic_out    = pin_sync[PD][2:0];
  assign mem_en_out          = mem_en_reg;

endmodule : pdm_port_regs

// ---- testbench/pdm_pin_world.sv ----
`timescale 1ns/1ns
module pdm_pin_world (
  input  wire logic [2:0][7:0] drv_abc_in,   // device levels
  input  wire logic [2:0][7:0] oe_abc_in,    // device enables
  input  wire logic [2:0][7:0] ext_abc_in,   // peripheral levels
  input  wire logic [2:0]      drv_d_in,     // port D levels
  input  wire logic [2:0]      oe_d_in,      // port D enables
  input  wire logic [2:0]      ext_d_in,     // peripheral levels D
  output logic      [2:0][7:0] wire_abc_out, // resolved pins
  output logic      [2:0]      wire_d_out    // resolved pins D
);
  // peripherals only win on pins the device has released
  assign wire_abc_out = (drv_abc_in & oe_abc_in) | (ext_abc_in & ~oe_abc_in);
  assign wire_d_out   = (drv_d_in & oe_d_in) | (ext_d_in & ~oe_d_in);
endmodule : pdm_pin_world

// ---- testbench/pdm_port_regs_bench.sv ----
`timescale 1ns/1ns
`include "pdm_cfg.svh"
module pdm_port_regs_bench;
  logic                  clk_sys_in = 1'h0;
  logic                  reset_in = 1'h1;
  logic                  io_reg_sel_in = 1'h1;
  pdm_pkg::pdm_bus_req_t bus_req_in = '0;
  pdm_pkg::pdm_cfg_t     cfg_in = '0;
  logic [2:0][7:0]       oe_term_abc_in = '0;
  logic [2:0][7:0]       cell_sel_abc_in = '0;
  logic [2:0][7:0]       ext_abc = {8'h66, 8'h99, 8'hC3};
  logic [2:0]            ext_d = 3'h0;
  logic [2:0]            oe_term_d_in = 3'h0;
  logic [2:0]            ecs_term_in = 3'h0;
  logic [2:0]            ecs_active_low_in = 3'h0;
  logic [2:0]            ecs_sel_in = 3'h0;
  logic [7:0]            cell_first_d_in = 8'h00;
  logic [7:0]            cell_second_d_in = 8'h00;
  logic [7:0]            bus_rdata_out, cell_first_out, cell_second_out;
  logic [2:0][7:0]       pin_abc_in, pin_abc_out, pin_abc_oe_out, logic_input_bus_out;
  logic [2:0]            pin_d_in, pin_d_out, pin_d_oe_out, port_d_logic_out;
  pdm_pkg::pdm_mem_en_t  mem_en_out;
  int                    miscompares = 0;
  int                    check_count = 0;
  int                    cycles = 0;

  pdm_port_regs dut_u (
    .clk_sys_in, .reset_in, .bus_req_in, .io_reg_sel_in, .bus_rdata_out, .cfg_in,
    .pin_abc_in, .pin_abc_out, .pin_abc_oe_out, .oe_term_abc_in, .cell_sel_abc_in,
    .pin_d_in, .pin_d_out, .pin_d_oe_out, .oe_term_d_in, .ecs_term_in, .ecs_active_low_in,
    .ecs_sel_in, .cell_first_d_in, .cell_second_d_in, .cell_first_out, .cell_second_out,
    .logic_input_bus_out, .port_d_logic_out, .mem_en_out
  );
  pdm_pin_world far_u (
    .drv_abc_in (pin_abc_out), .oe_abc_in (pin_abc_oe_out), .ext_abc_in (ext_abc),
    .drv_d_in (pin_d_out), .oe_d_in (pin_d_oe_out), .ext_d_in (ext_d),
    .wire_abc_out (pin_abc_in), .wire_d_out (pin_d_in)
  );

  // free-running clock
  always #5 clk_sys_in = ~clk_sys_in;

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // hang guard, far above the roughly one hundred cycles the tests need
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      miscompares++;
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // one bus cycle: request held across exactly one sampling edge
  task automatic bus_op(input logic [5:0] idx, input logic [1:0] port, input logic w,
                        input logic [7:0] d);
    @(posedge clk_sys_in);
    #1 bus_req_in = {idx, port, d, w, ~w};
    tick(1);
    bus_req_in.wr = 1'h0;
    bus_req_in.rd = 1'h0;
  endtask : bus_op

  task automatic rd_chk(input logic [5:0] idx, input logic [1:0] port, input logic [7:0] e);
    bus_op(idx, port, 1'h0, 8'h00);
    cmp(bus_rdata_out, e);
  endtask : rd_chk

  task automatic t_reset;
    cmp(pin_abc_oe_out, 24'h000000);
    rd_chk(`PDM_REG_MASK, 2'h0, 8'h00);
    rd_chk(`PDM_REG_DIR, 2'h2, 8'h00);
    $display("reset test done");
  endtask : t_reset

  task automatic t_data_out;
    bus_op(`PDM_REG_DATA_OUT, 2'h0, 1'h1, 8'hA5);
    bus_op(`PDM_REG_DIR, 2'h0, 1'h1, 8'h0F);
    tick(2);
    cmp(pin_abc_oe_out[0], 8'h0F);
    cmp(pin_abc_out[0] & 8'h0F, 8'h05);
    rd_chk(`PDM_REG_DATA_OUT, 2'h0, 8'hA5);
    rd_chk(`PDM_REG_EN_STAT, 2'h0, 8'h0F);
    oe_term_abc_in[0] = 8'h30;
    tick(2);
    cmp(pin_abc_oe_out[0], 8'h3F);
    bus_op(`PDM_REG_EN_STAT, 2'h0, 1'h1, 8'hFF);
    bus_op(`PDM_REG_DATA_IN, 2'h0, 1'h1, 8'h00);
    rd_chk(`PDM_REG_EN_STAT, 2'h0, 8'h3F);
    rd_chk(`PDM_REG_DATA_IN, 2'h0, 8'hE5);
    rd_chk(`PDM_REG_DATA_OUT, 2'h0, 8'hA5);
    // index 7 has no register: no mode control exists for port C
    bus_op(6'h07, 2'h2, 1'h1, 8'hFF);
    rd_chk(6'h07, 2'h2, 8'h00);
    rd_chk(`PDM_REG_DATA_OUT, 2'h2, 8'h00);
    cmp(pin_abc_out[2], 8'h00);
    $display("data out test done");
  endtask : t_data_out

  task automatic t_cells;
    cfg_in.logic_clock_sel = 1'h1;
    tick(1);
    bus_op(`PDM_REG_OCELL, 2'h0, 1'h1, 8'h3C);
    rd_chk(`PDM_REG_OCELL, 2'h0, 8'h3C);
    bus_op(`PDM_REG_MASK, 2'h0, 1'h1, 8'hF0);
    rd_chk(`PDM_REG_MASK, 2'h0, 8'hF0);
    bus_op(`PDM_REG_OCELL, 2'h0, 1'h1, 8'hFF);
    rd_chk(`PDM_REG_OCELL, 2'h0, 8'h3F);
    cmp(cell_first_out, 8'h3F);
    bus_op(`PDM_REG_MASK, 2'h3, 1'h1, 8'hFF);
    rd_chk(`PDM_REG_MASK, 2'h3, 8'h00);
    bus_op(`PDM_REG_OCELL, 2'h2, 1'h1, 8'h5A);
    cmp(cell_second_out, 8'h5A);
    rd_chk(`PDM_REG_OCELL, 2'h1, 8'h5A);
    cfg_in.route_first_to_b = 1'h1;
    rd_chk(`PDM_REG_OCELL, 2'h1, 8'h3F);
    cfg_in.route_first_to_b = 1'h0;
    cell_first_d_in = 8'h81;
    tick(3);
    cmp(cell_first_out, 8'h3F);
    ext_d[1] = 1'h1;
    tick(5);
    cmp(cell_first_out, 8'h81);
    cfg_in.logic_clock_sel = 1'h0;
    tick(4);
    rd_chk(`PDM_REG_ICELL, 2'h1, 8'h99);
    cmp(logic_input_bus_out[1], 8'h99);
    // port A pins show group 1, which now steps to the array value
    cell_sel_abc_in[0] = 8'hFF;
    tick(2);
    cmp(pin_abc_out[0], 8'h81);
    cell_sel_abc_in[0] = 8'h00;
    $display("cell test done");
  endtask : t_cells

  task automatic t_csi;
    cfg_in.csi_sel = 1'h1;
    ext_d[2] = 1'h1;
    tick(4);
    cmp(mem_en_out, 3'h0);
    bus_op(`PDM_REG_DATA_OUT, 2'h0, 1'h1, 8'h11);
    cell_first_d_in = 8'h42;
    tick(2);
    cmp(cell_first_out, 8'h42);
    ext_d[2] = 1'h0;
    tick(4);
    cmp(mem_en_out, 3'h7);
    io_reg_sel_in = 1'h0;
    bus_op(`PDM_REG_DATA_OUT, 2'h0, 1'h1, 8'h22);
    io_reg_sel_in = 1'h1;
    rd_chk(`PDM_REG_DATA_OUT, 2'h0, 8'hA5);
    $display("chip select test done");
  endtask : t_csi

  task automatic t_port_d;
    ecs_sel_in = 3'h7;
    ecs_term_in = 3'h5;
    ecs_active_low_in = 3'h3;
    oe_term_d_in = 3'h1;
    tick(2);
    cmp(pin_d_oe_out, 3'h1);
    cmp(pin_d_out, 3'h6);
    bus_op(`PDM_REG_DIR, 2'h3, 1'h1, 8'hFF);
    rd_chk(`PDM_REG_DIR, 2'h3, 8'h07);
    tick(4);
    cmp(pin_d_oe_out, 3'h7);
    cmp(port_d_logic_out, 3'h6);
    $display("port d test done");
  endtask : t_port_d

  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    #1 reset_in = 1'h0;
    tick(1);
    t_reset();
    t_data_out();
    t_cells();
    t_csi();
    t_port_d();
    final_report();
  end
endmodule : pdm_port_regs_bench

// ---- testbench/pdm_port_regs_props.sv ----
`timescale 1ns/1ns
module pdm_port_regs_props (
  input wire logic                  clk_sys_in,          // clock
  input wire logic                  reset_in,            // reset
  input wire pdm_pkg::pdm_bus_req_t bus_req_in,          // bus cycle
  input wire logic                  io_reg_sel_in,       // register decode
  input wire logic [7:0]            bus_rdata_out,       // read data
  input wire pdm_pkg::pdm_cfg_t     cfg_in,              // options
  input wire logic [2:0][7:0]       pin_abc_in,          // pins A..C
  input wire logic [2:0][7:0]       pin_abc_oe_out,      // enables A..C
  input wire logic [2:0][7:0]       oe_term_abc_in,      // terms A..C
  input wire logic [2:0]            pin_d_in,            // pins D
  input wire logic [2:0]            pin_d_oe_out,        // enables D
  input wire logic [2:0]            oe_term_d_in,        // terms D
  input wire logic [7:0]            cell_first_d_in,     // array next
  input wire logic [7:0]            cell_first_out,      // group 1
  input wire logic [2:0][7:0]       logic_input_bus_out, // input cells
  input wire logic [2:0]            port_d_logic_out,    // D direct
  input wire pdm_pkg::pdm_mem_en_t  mem_en_out           // memories
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  // a set term forces the driver on one cycle later
  chk_abc_term_on: assert property (
    !$past(reset_in) |-> (pin_abc_oe_out & $past(oe_term_abc_in)) == $past(oe_term_abc_in))
    else $error("abc driver off under term");
  chk_d_term_on: assert property (
    !$past(reset_in) |-> (pin_d_oe_out & $past(oe_term_d_in)) == $past(oe_term_d_in))
    else $error("port d driver off under term");
  chk_rdata_holds: assert property (
    !$past(reset_in) && !$past(bus_req_in.rd) |-> $stable(bus_rdata_out))
    else $error("read data moved without read");
  // select pin crosses two sync flops, so allow four cycles
  chk_csi_mem_off: assert property (
    (!reset_in && cfg_in.csi_sel && pin_d_in[2]) [*4] |=> mem_en_out == 3'h0)
    else $error("memories on under chip select");
  chk_csi_mem_on: assert property (
    !reset_in && !cfg_in.csi_sel && io_reg_sel_in |=> mem_en_out == 3'h7)
    else $error("memories off without chip select");
  chk_cell_steps: assert property (
    !reset_in && !cfg_in.logic_clock_sel && !bus_req_in.wr
    |=> cell_first_out == $past(cell_first_d_in))
    else $error("cell group 1 missed a step");
  chk_icell_follow: assert property (
    (!reset_in && !cfg_in.logic_clock_sel && $stable(pin_abc_in)) [*3]
    |=> logic_input_bus_out == $past(pin_abc_in))
    else $error("input cells lag pins");
  chk_d_direct_in: assert property (
    (!reset_in && $stable(pin_d_in)) [*3] |=> port_d_logic_out == $past(pin_d_in))
    else $error("port d direct input wrong");

  cover property (bus_req_in.wr);
  cover property (mem_en_out == 3'h0);
  cover property (cfg_in.logic_clock_sel && $rose(pin_d_in[1]));
endmodule : pdm_port_regs_props

bind pdm_port_regs pdm_port_regs_props chk_u (
  .clk_sys_in, .reset_in, .bus_req_in, .io_reg_sel_in, .bus_rdata_out, .cfg_in, .pin_abc_in,
  .pin_abc_oe_out, .oe_term_abc_in, .pin_d_in, .pin_d_oe_out, .oe_term_d_in,
  .cell_first_d_in, .cell_first_out, .logic_input_bus_out, .port_d_logic_out, .mem_en_out
);
